// [design/wdg_consts.svh]
// constants of the dual watchdog: field codes, levels, reset values
`ifndef WDG_CONSTS_SVH
`define WDG_CONSTS_SVH

// ****************************************
// window limit field codes
// ****************************************
`define WDG_WIN_HALF   2'h0
`define WDG_WIN_QUART  2'h1
`define WDG_WIN_EIGHTH 2'h2
`define WDG_WIN_OPEN   2'h3

// ****************************************
// levels, reset values and sleep mode codes
// ****************************************
`define WDG_IWD_WARN_COUNT 16'h0010
`define WDG_COUNT_RESET    16'h0000
`define WDG_SLEEP_MODE_0   2'h0
`define WDG_SLEEP_MODE_2   2'h2

`endif

// [design/wdg_pkg.sv]
// types of the dual watchdog top module; the counter keeps its own
package wdg_pkg;

   // per-watchdog life cycle
   typedef enum logic [1:0] {
      WDG_OFF,
      WDG_RUN,
      WDG_TRIP
   } wdg_state_t;

   // whole state of the top module
   typedef struct packed {
      wdg_state_t iwd_st;
      wdg_state_t wwd_st;
      logic       iwd_rst;
      logic       iwd_irq;
      logic       iwd_wake;
      logic       wwd_rst;
      logic       wwd_irq;
      logic       wwd_prohib;
   } wdg_top_state_t;

endpackage

// [design/wdg_cnt_if.sv]
// control and status lines between a watchdog and its down counter
`timescale 1ns/1ns
interface wdg_cnt_if #(parameter int CW = 16);
   logic          load;
   logic [CW-1:0] value;
   logic          run;
   logic [CW-1:0] count;
   logic          zero;

   modport ctl     (output load, value, run, input count, zero);
   modport counter (input load, value, run, output count, zero);
endinterface

// [design/wdg_counter.sv]
// loadable down counter that stops at zero
`timescale 1ns/1ns
`include "wdg_consts.svh"
module wdg_counter #(
   parameter int CW = 16
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   wdg_cnt_if.counter cnt
);

   typedef struct packed {
      logic [CW-1:0] count;
   } wdg_ctr_state_t;

   wdg_ctr_state_t st;
   wdg_ctr_state_t next_st;

   // load beats decrement so a reload is never lost
   always_comb begin
      next_st = st;
      if (cnt.load) begin
         next_st.count = cnt.value;
      end else if (cnt.run && st.count != '0) begin
         next_st.count = st.count - 1'b1;
      end
   end

   // ce low freezes the count
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st.count <= CW'(`WDG_COUNT_RESET);
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign cnt.count = st.count;
   assign cnt.zero  = (st.count == '0);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_load_takes_value: assert property (ce && cnt.load |=> cnt.count == $past(cnt.value)) // see (R1)
      else $error("counter did not take load value");
   a_count_steps_down: assert property (ce && cnt.run && !cnt.load && !cnt.zero // see (R1)
                                        |=> cnt.count == $past(cnt.count) - 1'b1)
      else $error("counter did not decrement");

endmodule // wdg_counter

// [design/wdg_dual_watchdog.sv]
// dual watchdog: free-running and windowed watchdogs with reset requests
//
// Summary of operation
// (R1) free-running counter decrements, reload write reloads it
// (R2) active free-running watchdog resets at zero
// (R3) free-running interrupt wakes sleep modes 0, 2
// (R4) refresh inside prohibited period causes reset
// (R5) window field sets period; 11 disables it
// (R6) windowed interrupt when prohibited period ends
// (R7) windowed overflow length comes from reload value
// (R8) windowed overflow without valid refresh causes reset
// (R9) reset request one registered pulse, then halt
// (R10) refresh outside the prohibited period at a nonzero count, in any window setting, reloads the windowed counter
`timescale 1ns/1ns
`include "wdg_consts.svh"
module wdg_dual_watchdog #(
   parameter int CW = 16
) (
   input  wire logic          CLK,
   input  wire logic          RESET_N,
   input  wire logic          CE,
   input  wire logic          IWD_ENABLE,
   input  wire logic [CW-1:0] IWD_RELOAD_VALUE,
   input  wire logic          IWD_RELOAD_WRITE,
   input  wire logic          SLEEP_ACTIVE,
   input  wire logic [1:0]    SLEEP_MODE,
   input  wire logic          WWD_ENABLE,
   input  wire logic [CW-1:0] WWD_RELOAD_VALUE,
   input  wire logic [1:0]    WWD_WINDOW,
   input  wire logic          WWD_REFRESH,
   output wire logic [CW-1:0] IWD_COUNT,
   output wire logic          IWD_RESET_REQ,
   output wire logic          IWD_IRQ,
   output wire logic          IWD_WAKE,
   output wire logic [CW-1:0] WWD_COUNT,
   output wire logic          WWD_RESET_REQ,
   output wire logic          WWD_IRQ
);

   // ****************************************
   // counters
   // ****************************************
   wdg_cnt_if #(.CW(CW)) iwd_cnt ();
   wdg_cnt_if #(.CW(CW)) wwd_cnt ();

   wdg_counter #(.CW(CW)) u_iwd_counter (
      .clk     (CLK),
      .reset_n (RESET_N),
      .ce      (CE),
      .cnt     (iwd_cnt.counter)
   );

   wdg_counter #(.CW(CW)) u_wwd_counter (
      .clk     (CLK),
      .reset_n (RESET_N),
      .ce      (CE),
      .cnt     (wwd_cnt.counter)
   );

   // ****************************************
   // control state
   // ****************************************
   wdg_pkg::wdg_top_state_t st;
   wdg_pkg::wdg_top_state_t next_st;
   logic [CW-1:0]           wwd_limit;
   logic                    wwd_prohib_now;
   logic                    wake_mode;

   // end of the prohibited period as a count; open window never prohibits
   always_comb begin
      case (WWD_WINDOW)
         `WDG_WIN_HALF:   wwd_limit = WWD_RELOAD_VALUE >> 1; // see (R5)
         `WDG_WIN_QUART:  wwd_limit = WWD_RELOAD_VALUE >> 2; // see (R5)
         `WDG_WIN_EIGHTH: wwd_limit = WWD_RELOAD_VALUE >> 3; // see (R5)
         default:         wwd_limit = WWD_RELOAD_VALUE;      // see (R5)
      endcase
   end

   assign wwd_prohib_now = (st.wwd_st == wdg_pkg::WDG_RUN) && (WWD_WINDOW != `WDG_WIN_OPEN)
                           && (wwd_cnt.count > wwd_limit); // see (R4)
   assign wake_mode      = SLEEP_ACTIVE && (SLEEP_MODE == `WDG_SLEEP_MODE_0
                                            || SLEEP_MODE == `WDG_SLEEP_MODE_2);

   // next state of both watchdogs; pulses clear themselves each step
   always_comb begin
      next_st            = st;
      next_st.iwd_rst    = 1'b0;
      next_st.iwd_irq    = 1'b0;
      next_st.iwd_wake   = 1'b0;
      next_st.wwd_rst    = 1'b0;
      next_st.wwd_irq    = 1'b0;
      next_st.wwd_prohib = wwd_prohib_now;
      iwd_cnt.load       = 1'b0;
      iwd_cnt.value      = IWD_RELOAD_VALUE;
      iwd_cnt.run        = (st.iwd_st == wdg_pkg::WDG_RUN);         // see (R1)
      wwd_cnt.load       = 1'b0;
      wwd_cnt.value      = WWD_RELOAD_VALUE;                        // see (R7)
      wwd_cnt.run        = (st.wwd_st == wdg_pkg::WDG_RUN);

      // free-running watchdog
      case (st.iwd_st)
         wdg_pkg::WDG_OFF: begin
            if (IWD_ENABLE) begin
               iwd_cnt.load   = 1'b1;
               next_st.iwd_st = wdg_pkg::WDG_RUN;
            end
         end
         wdg_pkg::WDG_RUN: begin
            if (iwd_cnt.zero) begin
               iwd_cnt.run     = 1'b0;
               next_st.iwd_rst = 1'b1;                             // see (R2)
               next_st.iwd_st  = wdg_pkg::WDG_TRIP;                // see (R9)
            end else if (IWD_RELOAD_WRITE) begin
               iwd_cnt.load = 1'b1;                                // see (R1)
            end else if (iwd_cnt.count == CW'(`WDG_IWD_WARN_COUNT)) begin
               next_st.iwd_irq  = 1'b1;
               next_st.iwd_wake = wake_mode;                       // see (R3)
            end
         end
         // stays halted until the system reset comes back
         default: iwd_cnt.run = 1'b0;                              // see (R9)
      endcase

      // windowed watchdog; overflow checked before refresh
      case (st.wwd_st)
         wdg_pkg::WDG_OFF: begin
            if (WWD_ENABLE) begin
               wwd_cnt.load   = 1'b1;
               next_st.wwd_st = wdg_pkg::WDG_RUN;
            end
         end
         wdg_pkg::WDG_RUN: begin
            if (wwd_cnt.zero) begin
               wwd_cnt.run     = 1'b0;
               next_st.wwd_rst = 1'b1;                             // see (R8)
               next_st.wwd_st  = wdg_pkg::WDG_TRIP;                // see (R9)
            end else if (WWD_REFRESH && wwd_prohib_now) begin
               wwd_cnt.run     = 1'b0;
               next_st.wwd_rst = 1'b1;                             // see (R4)
               next_st.wwd_st  = wdg_pkg::WDG_TRIP;                // see (R9)
            end else if (WWD_REFRESH) begin
               wwd_cnt.load = 1'b1;                                // see (R7)
            end else if (st.wwd_prohib && !wwd_prohib_now) begin
               next_st.wwd_irq = 1'b1;                             // see (R6)
            end
         end
         default: wwd_cnt.run = 1'b0;                              // see (R9)
      endcase
   end

   // ce low freezes every flop, pulses included
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         st.iwd_st     <= wdg_pkg::WDG_OFF;
         st.wwd_st     <= wdg_pkg::WDG_OFF;
         st.iwd_rst    <= 1'b0;
         st.iwd_irq    <= 1'b0;
         st.iwd_wake   <= 1'b0;
         st.wwd_rst    <= 1'b0;
         st.wwd_irq    <= 1'b0;
         st.wwd_prohib <= 1'b0;
      end else if (CE) begin
         st <= next_st;
      end
   end

   // outputs straight from flops
   assign IWD_COUNT     = iwd_cnt.count;
   assign IWD_RESET_REQ = st.iwd_rst;
   assign IWD_IRQ       = st.iwd_irq;
   assign IWD_WAKE      = st.iwd_wake;
   assign WWD_COUNT     = wwd_cnt.count;
   assign WWD_RESET_REQ = st.wwd_rst;
   assign WWD_IRQ       = st.wwd_irq;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);

   logic iwd_run;
   logic wwd_run;
   assign iwd_run = (st.iwd_st == wdg_pkg::WDG_RUN);
   assign wwd_run = (st.wwd_st == wdg_pkg::WDG_RUN);

   sequence s_iwd_hit_zero;
      CE && iwd_run && iwd_cnt.zero;
   endsequence
   // the pulse may outlast one cycle only while ce holds it frozen
   sequence s_pulse_then_quiet;
      IWD_RESET_REQ ##1 (!iwd_run && (!IWD_RESET_REQ || !$past(CE))) [*4];
   endsequence

   a_iwd_reload_write: assert property (CE && iwd_run && !iwd_cnt.zero // see (R1)
                                        && IWD_RELOAD_WRITE
                                        |=> IWD_COUNT == $past(IWD_RELOAD_VALUE))
      else $error("reload write did not reload free-running count");
   a_iwd_zero_reset: assert property (s_iwd_hit_zero |=> s_pulse_then_quiet) // see (R2)
      else $error("free-running zero did not give one reset pulse");
   // only a freshly set wake is checked; a frozen one keeps older inputs
   a_iwd_wake_mode: assert property (IWD_WAKE && $past(CE) |-> IWD_IRQ // see (R3)
                                     && $past(SLEEP_ACTIVE)
                                     && ($past(SLEEP_MODE) == 2'h0 || $past(SLEEP_MODE) == 2'h2))
      else $error("wake outside sleep mode 0 or 2");
   a_wwd_early_refresh: assert property (CE && wwd_run && !wwd_cnt.zero // see (R4)
                                         && WWD_REFRESH && WWD_WINDOW != 2'h3
                                         && WWD_COUNT > wwd_limit |=> WWD_RESET_REQ)
      else $error("early refresh gave no reset");
   a_wwd_open_window: assert property (CE && wwd_run && !wwd_cnt.zero && WWD_REFRESH // see (R5)
                                       && WWD_WINDOW == 2'h3 |=> !WWD_RESET_REQ
                                       && WWD_COUNT == $past(WWD_RELOAD_VALUE))
      else $error("open window refresh was refused");
   a_wwd_window_irq: assert property (WWD_IRQ && $past(CE) |-> $past(st.wwd_prohib) // see (R6)
                                      && !$past(wwd_prohib_now))
      else $error("window interrupt without end of prohibited period");
   a_wwd_overflow: assert property (CE && wwd_run && wwd_cnt.zero // see (R8)
                                    |=> WWD_RESET_REQ
                                    ##1 (!wwd_run && (!WWD_RESET_REQ || !$past(CE))))
      else $error("overflow gave no single reset pulse");
   a_wwd_trip_holds: assert property (CE && WWD_RESET_REQ |=> !wwd_run // see (R9)
                                      && $stable(WWD_COUNT) [*3])
      else $error("windowed counter ran after reset request");

endmodule // wdg_dual_watchdog

// [bench/wdg_dual_watchdog_tb.sv]
// self-checking bench of the dual watchdog against a cycle model
`timescale 1ns/1ns
`include "wdg_consts.svh"
module wdg_dual_watchdog_tb;
   localparam int CW = 16;
   logic          clk, reset_n, ce, iwd_en, iwd_wr, slp, wwd_en, wwd_ref;
   logic [CW-1:0] iwd_rv, wwd_rv, iwd_cnt, wwd_cnt;
   logic [1:0]    slp_mode, window_limit_field;
   logic          iwd_rst, iwd_irq, iwd_wake, wwd_rst, wwd_irq;
   logic [7:0]    lfsr;
   int            num_errors, total_checks, cycles, ic, wc, lim;
   bit            ion, itrip, won, wtrip, m_irst, m_iirq, m_wake, m_wrst, kick, ref_next;
   bit            m_wirq, m_prohib, pn;

   wdg_dual_watchdog #(.CW(CW)) i_wdg_dual_watchdog (
      .CLK(clk), .RESET_N(reset_n), .CE(ce), .IWD_ENABLE(iwd_en),
      .IWD_RELOAD_VALUE(iwd_rv), .IWD_RELOAD_WRITE(iwd_wr), .SLEEP_ACTIVE(slp),
      .SLEEP_MODE(slp_mode), .WWD_ENABLE(wwd_en), .WWD_RELOAD_VALUE(wwd_rv),
      .WWD_WINDOW(window_limit_field), .WWD_REFRESH(wwd_ref), .IWD_COUNT(iwd_cnt),
      .IWD_RESET_REQ(iwd_rst), .IWD_IRQ(iwd_irq), .IWD_WAKE(iwd_wake),
      .WWD_COUNT(wwd_cnt), .WWD_RESET_REQ(wwd_rst), .WWD_IRQ(wwd_irq));

   // 100 ns clock and a cycle ceiling against hangs
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles >= 20000) begin
         num_errors++;
         conclude();
      end
   end

   // ****************************************
   // reference model, one step per enabled edge
   // ****************************************
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         {ion, itrip, won, wtrip, m_irst, m_iirq, m_wake, m_wrst, m_wirq, m_prohib} = '0;
         ic = 0;
         wc = 0;
      end else if (ce) begin
         // open window has no prohibited period, so no limit at all
         lim = (window_limit_field == `WDG_WIN_OPEN) ? -1 : int'(wwd_rv >> (int'(window_limit_field) + 1));
         m_iirq = ion && ic == `WDG_IWD_WARN_COUNT;
         m_wake = m_iirq && slp && slp_mode inside {2'h0, 2'h2};
         m_irst = ion && ic == 0;
         m_wrst = won && (wc == 0 || (wwd_ref && lim >= 0 && wc > lim));
         // interrupt on the first unprohibited step, unless refreshed then
         pn = won && lim >= 0 && wc > lim;
         m_wirq = won && !m_wrst && !wwd_ref && m_prohib && !pn;
         m_prohib = pn;
         if (m_irst) begin
            ion = 0;
            itrip = 1;
         end else if (ion) begin
            ic = iwd_wr ? int'(iwd_rv) : ic - 1;
         end else if (!itrip && iwd_en) begin
            ion = 1;
            ic = int'(iwd_rv);
         end
         if (m_wrst) begin
            won = 0;
            wtrip = 1;
         end else if (won) begin
            wc = wwd_ref ? int'(wwd_rv) : wc - 1;
         end else if (!wtrip && wwd_en) begin
            won = 1;
            wc = int'(wwd_rv);
         end
      end
   end

   // ****************************************
   // compare tasks and stimulus step
   // ****************************************
   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   task automatic chk_count(input string what, input logic [CW-1:0] exp,
                            input logic [CW-1:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_flag(input string what, input logic exp, input logic got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
      end
   endtask

   // compare on the falling edge, then drive the next inputs
   task automatic step();
      @(negedge clk);
      chk_count("IWD_COUNT", CW'(ic), iwd_cnt);
      chk_count("WWD_COUNT", CW'(wc), wwd_cnt);
      chk_flag("IWD_RESET_REQ", m_irst, iwd_rst);
      chk_flag("IWD_IRQ", m_iirq, iwd_irq);
      chk_flag("IWD_WAKE", m_wake, iwd_wake);
      chk_flag("WWD_RESET_REQ", m_wrst, wwd_rst);
      chk_flag("WWD_IRQ", m_wirq, wwd_irq);
      lfsr = lfsr_next(lfsr);
      // a requested refresh always lands: ce is forced high with it
      ce = ref_next || lfsr[7:5] != 3'h0;
      slp = lfsr[1];
      slp_mode = lfsr[4:3];
      // reloads stay well above the warning count so the two never collide
      iwd_wr = kick && ion && ic > 48 && lfsr[2:0] == 3'h0;
      iwd_rv = 16'h0030 + CW'(lfsr[5:0]);
      wwd_ref = ref_next;
      ref_next = 1'b0;
   endtask

   task automatic do_reset();
      @(negedge clk);
      reset_n = 1'b0;
      {iwd_en, wwd_en, kick} = '0;
      repeat (5) @(negedge clk);
      reset_n = 1'b1;
   endtask

   // ****************************************
   // one scenario: early or in-window refreshes, then overflow
   // ****************************************
   task automatic scenario(input logic [1:0] w, input bit early);
      int t;
      do_reset();
      window_limit_field = w;
      wwd_rv = 16'h0040;
      step();
      step();
      iwd_en = 1'b1;
      wwd_en = 1'b1;
      kick = 1'b1;
      // early refresh lands while the count is still near the top
      if (early) begin
         repeat (5) step();
         ref_next = 1'b1;
         repeat (2) step();
      end
      for (int n = 0; n < 3; n++) begin
         t = 0;
         // two spare counts: the refresh lands one step after the wait
         while (won && wc > lim && wc > 2 && t < 300) begin
            step();
            t++;
         end
         ref_next = won;
         step();
         step();
      end
      kick = 1'b0;
      t = 0;
      while ((ion || won) && t < 400) begin
         step();
         t++;
      end
      chk_flag("both watchdogs tripped", 1'b1, t < 400);
      repeat (4) step();
      $display("test window %0d early %0d done", w, early);
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      {reset_n, ce, iwd_en, iwd_wr, slp, wwd_en, wwd_ref} = '0;
      {iwd_rv, wwd_rv, slp_mode, window_limit_field} = '0;
      lfsr = 8'h62;
      for (int w = 0; w < 4; w++) begin
         scenario(2'(w), 1'b1);
         scenario(2'(w), 1'b0);
      end
      conclude();
   end
endmodule // wdg_dual_watchdog_tb
